// *** hw/srl_defs.svh ***
`ifndef SRL_DEFS_SVH
`define SRL_DEFS_SVH

// =====================================================================
// widths and channel count
`define SRL_DATA_W        24
`define SRL_ADDR_W        5
`define SRL_NUM_CH        3
`define SRL_CTRL_LAST     7

// =====================================================================
// device address carried in the control byte
`define SRL_DEV_ADDR      2'h1

// =====================================================================
// register map landmarks
`define SRL_ADC_FIRST     5'h00
`define SRL_ADC_LAST      5'h02
`define SRL_TYPE1_FIRST   5'h03
`define SRL_TYPE1_LAST    5'h07
`define SRL_WR_FIRST      5'h08
`define SRL_MAP_LAST      5'h1f
`define SRL_PHASE_ADDR    5'h0a
`define SRL_LOCK_ADDR     5'h1f

// =====================================================================
// lock key and reset values
`define SRL_LOCK_KEY      8'ha5
`define SRL_LOCK_RST      24'h0000a5

// =====================================================================
// timing
`define SRL_CLK_MHZ           40
`define SRL_READY_TO_DATA_NS  100
`define SRL_READY_TO_DATA_RAW ((`SRL_READY_TO_DATA_NS * `SRL_CLK_MHZ) / 1000)
`define SRL_READY_TO_DATA_CYC \
  ((`SRL_READY_TO_DATA_RAW < 1) ? 1 : `SRL_READY_TO_DATA_RAW)

`endif

// *** hw/srl_pkg.sv ***
`default_nettype none

package srl_pkg;

  // =====================================================================
  // serial engine states, gray along idle, ctrl, read (write is two bits from ctrl)
  typedef enum logic [2:0] {
    SRL_IDLE  = 3'b000,
    SRL_CTRL  = 3'b001,
    SRL_READ  = 3'b011,
    SRL_WRITE = 3'b010,
    SRL_SKIP  = 3'b110
  } srl_state_t;

  // =====================================================================
  // address looping modes
  typedef enum logic [1:0] {
    SRL_LOOP_STATIC = 2'h0,
    SRL_LOOP_GROUPS = 2'h1,
    SRL_LOOP_TYPES  = 2'h2,
    SRL_LOOP_FULL   = 2'h3
  } srl_loop_t;

endpackage : srl_pkg

`default_nettype wire

// *** hw/srl_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface srl_mem_if #(
  parameter int DW = 24,
  parameter int AW = 5
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface : srl_mem_if

`default_nettype wire

// *** hw/srl_regmem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srl_defs.svh"

module srl_regmem
  import srl_pkg::*;
#(
  parameter int              DW      = `SRL_DATA_W,
  parameter int              AW      = `SRL_ADDR_W,
  parameter logic [DW-1:0]   LOCK_RV = `SRL_LOCK_RST
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  srl_mem_if.mem    mif
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;

  // =====================================================================
  // storage, lock word comes up holding the key
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
      mem_q[`SRL_LOCK_ADDR] <= LOCK_RV;
    end else if (mif.we) begin
      mem_q[mif.waddr] <= mif.wdata;
    end
  end

  // =====================================================================
  // registered read port
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[mif.raddr];
    end
  end

  assign mif.rdata = rdata_q;

endmodule : srl_regmem

`default_nettype wire

// *** hw/srl_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srl_defs.svh"

// Operation
// - control byte after select falls opens a transaction until select rises
// - start at control-byte address, advance in the set after each register
// - after the set's last address the pointer wraps to the set's first
// - read loop select: 00 static, 01 groups, 10 types, 11 full map
// - serial input after the control byte is ignored during reads
// - idle-low mode: after a read, output shows next word MSB on last fall
// - idle-low mode, clock low: output refreshed with new MSB on data-ready
// - idle-high mode: output holds last shifted bit after a complete read
// - write loop bit: 0 static, 1 types
// - serial output stays released throughout a write transaction
// - writes to non-writable addresses change nothing and do not advance
// - lock key other than 0xa5 leaves only 0x1f writable
// - phase write or converter setting change restarts the converters
// - restart clears converter data registers, converters resume alone
// - end of conversion gives active-low ready pulse of half modulator period
// - converter data updated within the ready-to-data delay after the pulse
// - ready pulses follow conversions and align to the output-rate clock
// - idle ready line released when idle-drive is 0, driven high when 1
// - ready pulses ignore select; line inactive while hard reset is low
// - checksum flag set holds the ready line low
// - data out on falling edges, in on rising; select rise aborts
// - control byte: device 7:6, register 5:1, read flag 0; output released
module srl_core
  import srl_pkg::*;
#(
  parameter int          DATA_W    = `SRL_DATA_W,
  parameter int          NUM_CH    = `SRL_NUM_CH,
  parameter logic [1:0]  DEV_ADDR  = `SRL_DEV_ADDR,
  parameter int          READY_TO_DATA_DELAY_CYC = `SRL_READY_TO_DATA_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     hard_reset_n_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     sck_i,
  input  wire logic                     sdi_i,
  output logic                          sdo_o,
  output logic                          sdo_oe_o,
  input  wire logic [1:0]               read_loop_sel_i,
  input  wire logic                     write_loop_i,
  input  wire logic                     ready_idle_drive_i,
  input  wire logic                     config_checksum_flag_i,
  input  wire logic [2:0]               oversampling_ratio_sel_i,
  input  wire logic [1:0]               prescale_sel_i,
  input  wire logic                     external_clock_sel_i,
  input  wire logic                     external_reference_sel_i,
  input  wire logic                     modulator_clock_i,
  input  wire logic                     output_rate_clock_i,
  input  wire logic [NUM_CH-1:0]        conversion_done_i,
  input  wire logic [NUM_CH*DATA_W-1:0] conv_data_i,
  output logic                          sample_ready_n_o,
  output logic                          sample_ready_n_oe_o,
  output logic                          converter_restart_o,
  output logic                          reg_locked_o,
  output logic                          write_blocked_o
);

  localparam int         CW         = $clog2(DATA_W);
  localparam logic [CW-1:0] WORD_LAST = CW'(DATA_W - 1);
  localparam logic [CW-1:0] CTRL_LAST = CW'(`SRL_CTRL_LAST);
  localparam logic [7:0] READY_TO_DATA_DELAY_LAST = 8'(READY_TO_DATA_DELAY_CYC);

  // =====================================================================
  // address set decoding
  function automatic logic [4:0] next_addr(input logic [1:0] sel,
                                           input logic [4:0] a);
    logic [4:0] first;
    logic [4:0] last;
    first = a;
    last  = a;
    case (sel)
      SRL_LOOP_GROUPS: begin
        first = {a[4:2], 2'b00};
        last  = {a[4:2], 2'b11};
      end
      SRL_LOOP_TYPES: begin
        if (a <= `SRL_ADC_LAST) begin
          first = `SRL_ADC_FIRST;
          last  = `SRL_ADC_LAST;
        end else if (a <= `SRL_TYPE1_LAST) begin
          first = `SRL_TYPE1_FIRST;
          last  = `SRL_TYPE1_LAST;
        end else begin
          first = `SRL_WR_FIRST;
          last  = `SRL_MAP_LAST;
        end
      end
      SRL_LOOP_FULL: begin
        first = `SRL_ADC_FIRST;
        last  = `SRL_MAP_LAST;
      end
      default: begin
        first = a;
        last  = a;
      end
    endcase
    next_addr = (a == last) ? first : a + 5'h01;
  endfunction : next_addr

  // =====================================================================
  // state
  srl_state_t          state_q;
  logic [CW-1:0]       bitcnt_q;
  logic [4:0]          ptr_q;
  logic                mode11_q;
  logic [DATA_W-1:0]   shift_q;
  logic [DATA_W-1:0]   word_q;
  logic                sdo_q;
  logic                sdo_oe_q;
  logic                sck_q;
  logic                mod_q;
  logic                rate_q;
  logic [7:0]          lock_q;
  logic [6:0]          cfg_q;
  logic                cfg_seen_q;
  logic                restart_q;
  logic                locked_q;
  logic                blocked_q;
  logic [NUM_CH-1:0]   pend_q;
  logic [NUM_CH-1:0]   pulse_ch_q;
  logic                pulse_q;
  logic [7:0]          dly_q;
  logic                dly_run_q;
  logic [DATA_W-1:0]   adc_q [NUM_CH];
  logic [NUM_CH-1:0]   adc_upd_q;
  logic                ready_n_q;
  logic                ready_oe_q;

  srl_mem_if #(.DW(DATA_W), .AW(5)) mif ();

  // =====================================================================
  // decode
  logic                rst_w;
  logic                sck_rise_w;
  logic                sck_fall_w;
  logic                mod_edge_w;
  logic                rate_rise_w;
  logic [7:0]          ctrl_byte_w;
  logic                dev_hit_w;
  logic                word_done_w;
  logic                writable_w;
  logic [DATA_W-1:0]   wr_word_w;
  logic                wr_fire_w;
  logic                wr_block_w;
  logic [1:0]          wr_sel_w;
  logic [CW-1:0]       bit_idx_w;
  logic                ptr_adc_w;
  logic [DATA_W-1:0]   rd_word_w;
  logic                refresh_w;
  logic [6:0]          cfg_w;
  logic                pulse_start_w;
  logic                commit_w;

  assign rst_w       = sys_rst_i | ~hard_reset_n_i;
  assign sck_rise_w  = sck_i & ~sck_q;
  assign sck_fall_w  = ~sck_i & sck_q;
  // modulator-side levels reach the edge logic unflopped, compared against one flopped copy
  assign mod_edge_w  = modulator_clock_i ^ mod_q;
  assign rate_rise_w = output_rate_clock_i & ~rate_q;
  assign ctrl_byte_w = {shift_q[6:0], sdi_i};
  assign dev_hit_w   = (ctrl_byte_w[7:6] == DEV_ADDR);
  assign word_done_w = (bitcnt_q == WORD_LAST);
  assign writable_w  = (ptr_q >= `SRL_WR_FIRST) &&
                       ((lock_q == `SRL_LOCK_KEY) ||
                        (ptr_q == `SRL_LOCK_ADDR));
  assign wr_word_w   = {shift_q[DATA_W-2:0], sdi_i};
  assign wr_fire_w   = (state_q == SRL_WRITE) && sck_rise_w &&
                       word_done_w && writable_w;
  assign wr_block_w  = (state_q == SRL_WRITE) && sck_rise_w &&
                       word_done_w && !writable_w;
  assign wr_sel_w    = write_loop_i ? SRL_LOOP_TYPES
                                    : SRL_LOOP_STATIC;
  assign bit_idx_w   = WORD_LAST - bitcnt_q;
  assign ptr_adc_w   = (ptr_q <= `SRL_ADC_LAST);
  assign rd_word_w   = ptr_adc_w ? adc_q[ptr_q[1:0]] : mif.rdata;
  assign refresh_w   = (state_q == SRL_READ) && !mode11_q && !sck_i &&
                       (bitcnt_q == '0) && ptr_adc_w &&
                       adc_upd_q[ptr_q[1:0]];
  assign cfg_w       = {oversampling_ratio_sel_i, prescale_sel_i,
                        external_clock_sel_i, external_reference_sel_i};
  assign pulse_start_w = rate_rise_w && (|pend_q) && !pulse_q &&
                         !restart_q;
  assign commit_w    = dly_run_q && (dly_q == 8'h01);

  assign mif.we    = wr_fire_w;
  assign mif.waddr = ptr_q;
  assign mif.wdata = wr_word_w;
  assign mif.raddr = ptr_q;

  srl_regmem #(
    .DW      (DATA_W),
    .AW      (5),
    .LOCK_RV (DATA_W'(`SRL_LOCK_RST))
  ) u_regmem (
    .clk_i     (clk_i),
    .sys_rst_i (rst_w),
    .mif       (mif.mem)
  );

  // =====================================================================
  // input edge samplers
  always_ff @(posedge clk_i) begin
    if (rst_w) begin
      sck_q  <= 1'b0;
      mod_q  <= 1'b0;
      rate_q <= 1'b0;
    end else begin
      sck_q  <= sck_i;
      mod_q  <= modulator_clock_i;
      rate_q <= output_rate_clock_i;
    end
  end

  // =====================================================================
  // serial engine
  always_ff @(posedge clk_i) begin
    if (rst_w || cs_n_i) begin
      state_q  <= SRL_IDLE;
      bitcnt_q <= '0;
      ptr_q    <= 5'h00;
      mode11_q <= 1'b0;
      shift_q  <= '0;
    end else if (state_q == SRL_IDLE) begin
      // clock level at select fall tells the two modes apart
      state_q  <= SRL_CTRL;
      mode11_q <= sck_i;
    end else if (sck_rise_w) begin
      case (state_q)
        SRL_CTRL: begin
          shift_q <= {shift_q[DATA_W-2:0], sdi_i};
          if (bitcnt_q == CTRL_LAST) begin
            bitcnt_q <= '0;
            ptr_q    <= ctrl_byte_w[5:1];
            if (!dev_hit_w) begin
              state_q <= SRL_SKIP;
            end else if (ctrl_byte_w[0]) begin
              state_q <= SRL_READ;
            end else begin
              state_q <= SRL_WRITE;
            end
          end else begin
            bitcnt_q <= bitcnt_q + 1'b1;
          end
        end
        SRL_READ: begin
          // serial input is not sampled at all here
          if (word_done_w) begin
            bitcnt_q <= '0;
            ptr_q    <= next_addr(read_loop_sel_i, ptr_q);
          end else begin
            bitcnt_q <= bitcnt_q + 1'b1;
          end
        end
        SRL_WRITE: begin
          shift_q <= {shift_q[DATA_W-2:0], sdi_i};
          if (word_done_w) begin
            bitcnt_q <= '0;
            if (writable_w) begin
              ptr_q <= next_addr(wr_sel_w, ptr_q);
            end
          end else begin
            bitcnt_q <= bitcnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // =====================================================================
  // serial output; a fall drives bit (last - rises done), both modes
  always_ff @(posedge clk_i) begin
    if (rst_w || cs_n_i) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
      word_q   <= '0;
    end else begin
      sdo_oe_q <= (state_q == SRL_READ);
      if ((state_q == SRL_READ) && sck_fall_w) begin
        if (bitcnt_q == '0) begin
          word_q <= rd_word_w;
          sdo_q  <= rd_word_w[DATA_W-1];
        end else begin
          sdo_q  <= word_q[bit_idx_w];
        end
      end else if (refresh_w) begin
        word_q <= rd_word_w;
        sdo_q  <= rd_word_w[DATA_W-1];
      end
      // idle-high mode sees no trailing fall, so the lsb stays put
    end
  end

  // =====================================================================
  // lock shadow, restart detection, write status
  always_ff @(posedge clk_i) begin
    if (rst_w) begin
      lock_q     <= `SRL_LOCK_KEY;
      cfg_q      <= '0;
      cfg_seen_q <= 1'b0;
      restart_q  <= 1'b0;
      locked_q   <= 1'b0;
      blocked_q  <= 1'b0;
    end else begin
      cfg_q      <= cfg_w;
      cfg_seen_q <= 1'b1;
      // same-value phase writes count too: serial soft reset path
      restart_q  <= (wr_fire_w && (ptr_q == `SRL_PHASE_ADDR)) ||
                    (cfg_seen_q && (cfg_w != cfg_q));
      if (wr_fire_w && (ptr_q == `SRL_LOCK_ADDR)) begin
        lock_q <= wr_word_w[7:0];
      end
      locked_q   <= (lock_q != `SRL_LOCK_KEY);
      blocked_q  <= wr_block_w;
    end
  end

  // =====================================================================
  // data-ready pulse and ready-to-data delay
  always_ff @(posedge clk_i) begin
    if (rst_w) begin
      pend_q     <= '0;
      pulse_ch_q <= '0;
      pulse_q    <= 1'b0;
      dly_q      <= 8'h00;
      dly_run_q  <= 1'b0;
    end else if (restart_q) begin
      pend_q     <= '0;
      pulse_q    <= 1'b0;
      dly_run_q  <= 1'b0;
    end else if (pulse_start_w) begin
      pulse_q    <= 1'b1;
      pulse_ch_q <= pend_q;
      pend_q     <= conversion_done_i;
      dly_q      <= READY_TO_DATA_DELAY_LAST;
      dly_run_q  <= 1'b1;
    end else begin
      pend_q <= pend_q | conversion_done_i;
      if (pulse_q && mod_edge_w) begin
        pulse_q <= 1'b0;
      end
      if (dly_run_q) begin
        dly_q <= dly_q - 8'h01;
        if (dly_q == 8'h01) begin
          dly_run_q <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // converter data registers, one per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_adc
      always_ff @(posedge clk_i) begin
        if (rst_w || restart_q) begin
          adc_q[g]     <= '0;
          adc_upd_q[g] <= 1'b0;
        end else begin
          adc_upd_q[g] <= commit_w && pulse_ch_q[g];
          if (commit_w && pulse_ch_q[g]) begin
            adc_q[g] <= conv_data_i[g*DATA_W +: DATA_W];
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // ready pin; select plays no part here
  always_ff @(posedge clk_i) begin
    if (rst_w) begin
      ready_n_q  <= 1'b1;
      ready_oe_q <= 1'b0;
    end else if (config_checksum_flag_i) begin
      ready_n_q  <= 1'b0;
      ready_oe_q <= 1'b1;
    end else begin
      ready_n_q  <= ~pulse_q;
      ready_oe_q <= pulse_q | ready_idle_drive_i;
    end
  end

  assign sdo_o               = sdo_q;
  assign sdo_oe_o            = sdo_oe_q;
  assign sample_ready_n_o    = ready_n_q;
  assign sample_ready_n_oe_o = ready_oe_q;
  assign converter_restart_o = restart_q;
  assign reg_locked_o        = locked_q;
  assign write_blocked_o     = blocked_q;

endmodule : srl_core

`default_nettype wire

// *** verification/srl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module srl_props (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       hard_reset_n_i,
  input wire logic       cs_n_i,
  input wire logic       sdo_oe_o,
  input wire logic       ready_idle_drive_i,
  input wire logic       config_checksum_flag_i,
  input wire logic [2:0] oversampling_ratio_sel_i,
  input wire logic [1:0] prescale_sel_i,
  input wire logic       external_clock_sel_i,
  input wire logic       external_reference_sel_i,
  input wire logic       output_rate_clock_i,
  input wire logic       sample_ready_n_o,
  input wire logic       sample_ready_n_oe_o,
  input wire logic       converter_restart_o
);
  // ====================================================================
  // serial and ready line relations
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i || !hard_reset_n_i);
  a_ctrl_quiet: assert property ($fell(cs_n_i) |-> !sdo_oe_o [*8])
    else $error("serial output driven in control byte");
  a_cs_release: assert property (cs_n_i [*3] |-> !sdo_oe_o)
    else $error("serial output driven while deselected");
  a_csum_low: assert property (config_checksum_flag_i
    |=> !sample_ready_n_o && sample_ready_n_oe_o)
    else $error("ready line not held low on checksum flag");
  a_hard_idle: assert property (disable iff (sys_rst_i)
    !hard_reset_n_i |=> !sample_ready_n_oe_o)
    else $error("ready line driven in hard reset");
  a_idle_drive: assert property (sample_ready_n_o && !$past(sys_rst_i)
    && $past(hard_reset_n_i) && !$past(config_checksum_flag_i)
    && $stable(ready_idle_drive_i)
    |-> sample_ready_n_oe_o == ready_idle_drive_i)
    else $error("idle ready drive wrong");
  a_pulse_drive: assert property (!sample_ready_n_o
    |-> sample_ready_n_oe_o)
    else $error("ready pulse not driven");
  a_pulse_width: assert property ($fell(sample_ready_n_o)
    && !config_checksum_flag_i |-> ##[1:8] sample_ready_n_o)
    else $error("ready pulse too long");
  a_rate_sync: assert property ($fell(sample_ready_n_o)
    && !config_checksum_flag_i |-> $past(output_rate_clock_i))
    else $error("ready pulse off the rate clock");
  a_restart_cfg: assert property ($changed({oversampling_ratio_sel_i,
    prescale_sel_i, external_clock_sel_i, external_reference_sel_i})
    |-> ##[0:2] converter_restart_o)
    else $error("no restart on setting change");
endmodule : srl_props
`default_nettype wire

// *** verification/srl_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module srl_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o
);
  // ====================================================================
  // master side of the serial link
  logic [23:0] tx [8];
  logic [23:0] rx [8];
  logic        tail;
  wire         line;
  // no pull on the line: released shows the inverse, never a stale bit
  assign line = sdo_oe_i ? sdo_i : ~sdo_i;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] c, input int n, input logic md);
    int w;
    sck_o <= md;
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int b = 0; b < 8 + 24 * n; b++) begin
      w = (b < 8) ? 0 : (b - 8) / 24;
      sck_o <= 1'b0;
      sdi_o <= (b < 8) ? c[7 - b] : tx[w][23 - (b - 8) % 24];
      repeat (4) @(posedge clk_i);
      if (b >= 8) rx[w][23 - (b - 8) % 24] = line;
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    sck_o <= md;
    repeat (4) @(posedge clk_i);
    tail = line;
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : xfer
endmodule : srl_host
`default_nettype wire

// *** verification/tb_spi_register_loop_and_data_ready.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srl_defs.svh"
module tb_spi_register_loop_and_data_ready;
  logic        clk_i, mclk = 1'b0, rclk = 1'b0;
  logic        sys_rst_i = 1'b1, hard_reset_n_i = 1'b1;
  wire         cs_n_i, sck_i, sdi_i, sdo_o, sdo_oe_o;
  wire         rdy_n, rdy_oe, restart, locked, blocked;
  logic [1:0]  read_loop_sel_i = 2'h2;
  logic        write_loop_i = 1'b1, csum = 1'b0;
  logic        idle_drv = 1'b1;
  logic [6:0]  cfg = 7'h0;
  logic [2:0]  done = 3'h0;
  logic [71:0] cdata = 72'h0;
  int          seed = 32, errors = 0, n_checks = 0;
  int          exp_blk = 0, exp_rst = 0, n_blk = 0, n_rst = 0;
  logic        wr_act = 1'b0, oe_wr = 1'b0;
  logic [4:0]  cnt = 5'h0;
  logic [23:0] mem_m [32];
  logic [23:0] adc_m [3];
  srl_core dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hard_reset_n_i(hard_reset_n_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .read_loop_sel_i(read_loop_sel_i),
    .write_loop_i(write_loop_i), .ready_idle_drive_i(idle_drv),
    .config_checksum_flag_i(csum), .oversampling_ratio_sel_i(cfg[6:4]),
    .prescale_sel_i(cfg[3:2]), .external_clock_sel_i(cfg[1]),
    .external_reference_sel_i(cfg[0]), .modulator_clock_i(mclk),
    .output_rate_clock_i(rclk), .conversion_done_i(done),
    .conv_data_i(cdata), .sample_ready_n_o(rdy_n),
    .sample_ready_n_oe_o(rdy_oe), .converter_restart_o(restart),
    .reg_locked_o(locked), .write_blocked_o(blocked));
  srl_host host_u (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i));
  // ====================================================================
  // clocks and monitors
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cnt <= cnt + 5'h1;
    mclk <= cnt[2];
    rclk <= cnt[4];
    if (blocked === 1'b1) n_blk <= n_blk + 1;
    if (restart === 1'b1) n_rst <= n_rst + 1;
    if (wr_act && sdo_oe_o !== 1'b0) oe_wr <= 1'b1;
  end
  // ====================================================================
  // expectation and transfer helpers
  function automatic logic [4:0] nxt(input logic [4:0] a, logic [1:0] m);
    case (m)
      2'h0: nxt = a;
      2'h1: nxt = (a[1:0] == 2'h3) ? {a[4:2], 2'h0} : a + 5'h1;
      2'h2: nxt = (a == 5'h02) ? 5'h00 : (a == 5'h07) ? 5'h03 :
                  (a == 5'h1f) ? 5'h08 : a + 5'h1;
      default: nxt = a + 5'h1;
    endcase
  endfunction : nxt
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic fill;
    for (int i = 0; i < 8; i++) host_u.tx[i] = 24'($random(seed));
  endtask : fill
  task automatic wr(input logic [4:0] a, input int n, input int lo);
    logic [4:0] p;
    p = a;
    fill();
    if (lo >= 0) host_u.tx[0][7:0] = lo[7:0];
    wr_act = 1'b1;
    host_u.xfer({`SRL_DEV_ADDR, a, 1'b0}, n, 1'b0);
    wr_act = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (p < `SRL_WR_FIRST || (p != `SRL_LOCK_ADDR &&
          mem_m[`SRL_LOCK_ADDR][7:0] != `SRL_LOCK_KEY)) begin
        exp_blk++;
      end else begin
        mem_m[p] = host_u.tx[i];
        if (p == `SRL_PHASE_ADDR) exp_rst++;
        if (p == `SRL_PHASE_ADDR) adc_m = '{default: 24'h0};
        if (write_loop_i) p = nxt(p, 2'h2);
      end
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, input int n, input logic md);
    logic [4:0] p;
    p = a;
    fill();
    host_u.xfer({`SRL_DEV_ADDR, a, 1'b1}, n, md);
    for (int i = 0; i < n; i++) begin
      chk("rdata", p < 5'h03 ? adc_m[p] : mem_m[p], host_u.rx[i]);
      p = nxt(p, read_loop_sel_i);
    end
  endtask : rd
  task automatic results;
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    results();
  end
  // ====================================================================
  // scenarios
  initial begin
    for (int i = 0; i < 32; i++) mem_m[i] = 24'h0;
    mem_m[`SRL_LOCK_ADDR] = `SRL_LOCK_RST;
    adc_m = '{default: 24'h0};
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("locked", 24'h0, 24'(locked));
    wr(5'h08, 5, -1);
    for (int i = 0; i < 4; i++) begin
      read_loop_sel_i <= 2'(i);
      rd(5'h0b, 2, 1'b0);
    end
    wr(5'h03, 1, -1);
    wr(5'h05, 1, -1);
    write_loop_i <= 1'b0;
    wr(5'h0d, 2, -1);
    rd(5'h0d, 1, 1'b0);
    write_loop_i <= 1'b1;
    wr(5'h1f, 1, 0);
    chk("locked", 24'h1, 24'(locked));
    wr(5'h08, 1, -1);
    wr(5'h1f, 1, 8'ha5);
    chk("locked", 24'h0, 24'(locked));
    chk("blocked", 24'(exp_blk), 24'(n_blk));
    cdata <= 72'({$random(seed), $random(seed), $random(seed)});
    done <= 3'h7;
    @(posedge clk_i);
    done <= 3'h0;
    repeat (60) @(posedge clk_i);
    for (int i = 0; i < 3; i++) adc_m[i] = cdata[i*24 +: 24];
    read_loop_sel_i <= 2'h2;
    rd(5'h00, 4, 1'b0);
    rd(5'h01, 1, 1'b1);
    chk("tail", 24'(adc_m[1][0]), 24'(host_u.tail));
    wr(5'h0a, 1, -1);
    read_loop_sel_i <= 2'h0;
    rd(5'h02, 1, 1'b0);
    host_u.xfer({~`SRL_DEV_ADDR, 5'h08, 1'b1}, 1, 1'b0);
    chk("foreign", 24'hffffff, host_u.rx[0]);
    for (int i = 0; i < 7; i++) begin
      cfg <= cfg ^ (7'h01 << i);
      exp_rst++;
      repeat (8) @(posedge clk_i);
    end
    chk("restart", 24'(exp_rst), 24'(n_rst));
    csum <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("ready", 24'h0, 24'(rdy_n));
    chk("ready_oe", 24'h1, 24'(rdy_oe));
    csum <= 1'b0;
    idle_drv <= 1'b0;
    done <= 3'h2;
    @(posedge clk_i);
    done <= 3'h0;
    repeat (70) @(posedge clk_i);
    chk("ready_oe", 24'h0, 24'(rdy_oe));
    idle_drv <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("ready_oe", 24'h1, 24'(rdy_oe));
    hard_reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("ready_oe", 24'h0, 24'(rdy_oe));
    chk("oe_in_write", 24'h0, 24'(oe_wr));
    results();
  end
endmodule : tb_spi_register_loop_and_data_ready
bind srl_core srl_props chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hard_reset_n_i(hard_reset_n_i),
  .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
  .ready_idle_drive_i(ready_idle_drive_i),
  .config_checksum_flag_i(config_checksum_flag_i),
  .oversampling_ratio_sel_i(oversampling_ratio_sel_i),
  .prescale_sel_i(prescale_sel_i),
  .external_clock_sel_i(external_clock_sel_i),
  .external_reference_sel_i(external_reference_sel_i),
  .output_rate_clock_i(output_rate_clock_i),
  .sample_ready_n_o(sample_ready_n_o),
  .sample_ready_n_oe_o(sample_ready_n_oe_o),
  .converter_restart_o(converter_restart_o));
`default_nettype wire
